// ==== design/pss_seq_top.sv ====
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.svh"

// Functional notes
// - software setting the hibernate bit moves active to hibernate.
// - edge or level hibernate gpio request also moves active to hibernate.
// - leave hibernate on level release with bit clear, edge request, or start-up.
// - any fault while hibernating goes to off.
// - hibernate bit is bit 15 of hibernate control, 1 is hibernate, resets 0.
// - fast charging inhibited in hibernate, trickle charging still allowed.
// - qualified start-up event moves off or hibernate to active.
// - on key held active over 40ms, polarity selectable, is a start-up event.
// - wake gpio held active over 40ms, per-pin polarity, is a start-up event.
// - power-on gpio held active over 40ms, per-pin polarity, is a start-up event.
// - rtc alarm is a start-up event when alarm wake is enabled.
// - adaptor or usb supply rising above 4.0V is a start-up event.
// - start-up events ignored unless line supply is above the threshold.
// - usb start with suspend uses battery; otherwise usb power plus 100mA trickle.
// - battery connection alone never starts; battery start needs a real event.
// - wake cause flags occupy bits 6 to 0 of the status register.
// - flags set on condition rising edge and clear when status is read.
// - wake summary interrupt asserts whenever any unmasked flag is set.
// - mask bits 6 to 0 gate matching flags, 1 masks, default 0.
// - start-up from off runs a fourteen slot sequence enabling each supply once.
// - advance after 1.28ms once supplies of this slot reach 90 percent.
// - on key polarity 0 is active high, 1 active low, reset active low.
// - restart enabled: retry up to 8 times at 200ms, then off, clear count.
module pss_seq_top #(
    parameter int unsigned QUAL_CYC  = `PSS_QUAL_CYC,
    parameter int unsigned SLOT_CYC  = `PSS_SLOT_CYC,
    parameter int unsigned RETRY_CYC = `PSS_RETRY_CYC
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    // avalon-mm slave
    input  wire logic [9:0]           i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [31:0]          i_avs_writedata,
    input  wire logic [3:0]           i_avs_byteenable,
    output logic [31:0]               o_avs_readdata,
    output logic                      o_avs_waitrequest,
    // start-up and hibernate sources
    input  wire logic                 i_on_key,
    input  wire logic                 i_gpio_wake,
    input  wire logic                 i_power_on_request_input,
    input  wire logic                 i_rtc_alarm,
    input  wire logic                 i_adaptor_sense_input,
    input  wire logic                 i_usb_above_4v,
    input  wire logic                 i_line_above_thr,
    input  wire logic                 i_hib_edge_req,
    input  wire logic                 i_hib_level_req,
    input  wire logic                 i_watchdog_reset,
    // supply blocks
    input  wire logic [`PSS_NSUP-1:0] i_supply_good,
    input  wire logic                 i_supply_fault,
    output logic [`PSS_NSUP-1:0]      o_supply_en,
    output logic [2:0]                o_startup_voltage_threshold,
    output logic                      o_fast_charge_allow,
    output logic                      o_usb_trickle_100ma,
    output logic                      o_start_on_battery,
    output logic                      o_wake_summary_irq
);
    import pss_pkg::*;

    // decode of a word index from a byte address
    function automatic logic [7:0] word_idx(input logic [9:0] a);
        return a[9:2];
    endfunction

    // merge a 16-bit register with byte-lane writes
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    pss_state_t          state_reg;
    pss_state_t          state_next;
    logic [15:0]         hib_reg;
    logic [15:0]         stat_reg;
    logic [15:0]         mask_reg;
    logic [15:0]         cfg_reg;
    logic [3:0]          slot_map [`PSS_NSUP];
    logic [3:0]          slot_reg;
    logic [3:0]          retry_reg;
    pss_count_t          tmr_reg;
    logic                edge_hib_reg;
    logic                hib_edge_d_reg;
    logic                wall_d_reg;
    logic                usb_d_reg;
    logic                wdog_d_reg;
    logic                wait_reg;
    logic [31:0]         rdata_reg;
    logic [`PSS_NSUP-1:0] en_reg;
    logic                fast_reg;
    logic                trickle_reg;
    logic                batt_reg;
    logic                irq_reg;

    pss_qual_if q_key ();
    pss_qual_if q_wake ();
    pss_qual_if q_pwr ();

    // hold-time qualifiers for key and gpio requests
    pss_qual #(.CYCLES(QUAL_CYC)) u_key  (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .q(q_key));
    pss_qual #(.CYCLES(QUAL_CYC)) u_wake (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .q(q_wake));
    pss_qual #(.CYCLES(QUAL_CYC)) u_pwr  (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .q(q_pwr));

    // qualifier levels after polarity selection
    assign q_key.ce     = i_ce;
    assign q_wake.ce    = i_ce;
    assign q_pwr.ce     = i_ce;
    assign q_key.level  = i_on_key ^ cfg_reg[`PSS_CFG_ONPOL];
    assign q_wake.level = i_gpio_wake ^ cfg_reg[`PSS_CFG_WAKEPOL];
    assign q_pwr.level  = i_power_on_request_input ^ cfg_reg[`PSS_CFG_PWRPOL];

    // bus decode
    wire [7:0] idx      = word_idx(i_avs_address);
    wire       req      = i_avs_read | i_avs_write;
    wire       done     = req && !wait_reg;
    wire       wr       = done && i_avs_write;
    wire       rd_stat  = done && i_avs_read && (idx == `PSS_IDX_STAT);
    wire       slot_hit = (idx >= `PSS_IDX_SLOT0) && (idx < `PSS_IDX_SLOT0 + 8'(`PSS_NSUP));
    wire [3:0] slot_sel = 4'(idx - `PSS_IDX_SLOT0);
    wire       hib_bit  = hib_reg[`PSS_HIB_BIT];

    // start-up sources
    // alarm gated by its enable
    wire alarm_ev = i_rtc_alarm && cfg_reg[`PSS_CFG_ALARM];
    wire wall_ev  = i_adaptor_sense_input && !wall_d_reg;
    wire usb_ev   = i_usb_above_4v && !usb_d_reg;
    wire startup  = i_line_above_thr &&
                    (q_key.hit | q_wake.hit | q_pwr.hit | alarm_ev | wall_ev | usb_ev);
    wire hib_edge = i_hib_edge_req && !hib_edge_d_reg;
    wire wdog_ev  = i_watchdog_reset && !wdog_d_reg;

    // sequencer slot bookkeeping
    wire       tmr_done = (tmr_reg == pss_count_t'(SLOT_CYC - 1));
    wire       rty_done = (tmr_reg == pss_count_t'(RETRY_CYC - 1));
    logic [`PSS_NSUP-1:0] in_slot;
    always_comb begin
        for (int i = 0; i < `PSS_NSUP; i++)
            in_slot[i] = (slot_map[i] == slot_reg);
    end
    // all supplies of this slot at 90 percent
    wire slot_ok   = &(i_supply_good | ~in_slot);
    wire last_slot = (slot_reg == `PSS_LAST_SLOT);
    wire can_retry = cfg_reg[`PSS_CFG_RESTART] && (retry_reg != `PSS_RETRY_MAX);

    // state transitions
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            st_off:    if (startup) state_next = st_seq;
            st_seq: begin
                if (i_supply_fault)
                    state_next = can_retry ? st_retry : st_off;
                else if (tmr_done && slot_ok && last_slot)
                    state_next = st_active;
            end
            st_active: begin
                if (i_supply_fault)
                    state_next = can_retry ? st_retry : st_off;
                else if (hib_bit || hib_edge || i_hib_level_req)
                    state_next = st_hib;
            end
            st_hib: begin
                if (i_supply_fault)
                    state_next = st_off;
                else if (startup || hib_edge ||
                         (!edge_hib_reg && !i_hib_level_req && !hib_bit))
                    state_next = st_active;
            end
            st_retry:  if (rty_done) state_next = st_seq;
            default:   state_next = st_off;
        endcase
    end

    // wake cause set terms
    logic [15:0] stat_set;
    always_comb begin
        stat_set = '0;
        stat_set[`PSS_F_OFF]  = (state_reg == st_off) && startup;
        stat_set[`PSS_F_HIB]  = (state_reg == st_hib) && (state_next == st_active);
        stat_set[`PSS_F_CONV] = (state_next == st_retry) && (state_reg != st_retry);
        stat_set[`PSS_F_WDOG] = wdog_ev;
        stat_set[`PSS_F_PWR]  = q_pwr.hit && i_line_above_thr;
        stat_set[`PSS_F_KEY]  = q_key.hit && i_line_above_thr;
        stat_set[`PSS_F_WAKE] = q_wake.hit && i_line_above_thr;
    end
    // set beats read clear; only flags already returned are cleared
    wire [15:0] stat_next = (rd_stat ? stat_reg & ~rdata_reg[15:0] : stat_reg) | stat_set;

    // readback mux
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (idx == `PSS_IDX_HIB)       rd_mux = hib_reg;
        else if (idx == `PSS_IDX_STAT) rd_mux = stat_reg;
        else if (idx == `PSS_IDX_MASK) rd_mux = mask_reg;
        else if (idx == `PSS_IDX_CFG)  rd_mux = cfg_reg;
        else if (idx == `PSS_IDX_INFO)
            rd_mux = {5'h00, state_reg, retry_reg, slot_reg};
        else if (slot_hit)             rd_mux = {12'h000, slot_map[slot_sel]};
    end

    // bus handshake: one wait cycle, then answer
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else if (i_ce) begin
            wait_reg <= !(req && wait_reg);
            if (req && wait_reg)
                rdata_reg <= {16'h0000, rd_mux};
        end
    end

    // software registers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hib_reg  <= 16'h0000;
            mask_reg <= 16'h0000;
            cfg_reg  <= `PSS_CFG_RST;
        end else if (i_ce) begin
            if (wr && idx == `PSS_IDX_HIB)
                hib_reg <= lane_merge(hib_reg, i_avs_writedata, i_avs_byteenable);
            else if (state_next == st_off)
                hib_reg <= 16'h0000;
            if (wr && idx == `PSS_IDX_MASK)
                mask_reg <= lane_merge(mask_reg, i_avs_writedata, i_avs_byteenable)
                            & `PSS_STAT_MASK;
            if (wr && idx == `PSS_IDX_CFG)
                cfg_reg <= lane_merge(cfg_reg, i_avs_writedata, i_avs_byteenable);
        end
    end

    // slot assignment table
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < `PSS_NSUP; i++)
                slot_map[i] <= `PSS_SLOT_RST;
        end else if (i_ce && wr && slot_hit && i_avs_byteenable[0]) begin
            slot_map[slot_sel] <= i_avs_writedata[3:0];
        end
    end

    // status flags and summary interrupt
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_reg <= 16'h0000;
            irq_reg  <= 1'b0;
        end else if (i_ce) begin
            stat_reg <= stat_next;
            irq_reg  <= |(stat_next & ~mask_reg);
        end
    end

    // edge detectors for plug-in, hibernate edge and watchdog
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wall_d_reg     <= 1'b0;
            usb_d_reg      <= 1'b0;
            hib_edge_d_reg <= 1'b0;
            wdog_d_reg     <= 1'b0;
        end else if (i_ce) begin
            wall_d_reg     <= i_adaptor_sense_input;
            usb_d_reg      <= i_usb_above_4v;
            hib_edge_d_reg <= i_hib_edge_req;
            wdog_d_reg     <= i_watchdog_reset;
        end
    end

    // state, slot, timer and retry counter
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg    <= st_off;
            slot_reg     <= 4'h0;
            tmr_reg      <= '0;
            retry_reg    <= 4'h0;
            edge_hib_reg <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                tmr_reg  <= '0;
                slot_reg <= 4'h0;
            // empty slot still waits the full delay
            end else if (state_reg == st_seq && tmr_done) begin
                if (slot_ok) begin
                    slot_reg <= slot_reg + 4'h1;
                    tmr_reg  <= '0;
                end
            end else if (state_reg == st_seq || state_reg == st_retry) begin
                tmr_reg <= tmr_reg + 24'h000001;
            end
            // count attempts, clear on success or give-up
            if (state_next == st_retry && state_reg != st_retry)
                retry_reg <= retry_reg + 4'h1;
            else if (state_next == st_active || state_next == st_off)
                retry_reg <= 4'h0;
            if (state_reg == st_active && state_next == st_hib)
                edge_hib_reg <= hib_edge && !hib_bit && !i_hib_level_req;
        end
    end

    // supply enables and charger controls
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_reg      <= '0;
            fast_reg    <= 1'b0;
            trickle_reg <= 1'b0;
            batt_reg    <= 1'b0;
        end else if (i_ce) begin
            // each supply switched on in its own slot
            if (state_next == st_off || state_next == st_retry)
                en_reg <= '0;
            else if (state_reg == st_seq)
                en_reg <= en_reg | in_slot;
            fast_reg <= (state_next == st_active);
            if (state_reg == st_off && startup && usb_ev) begin
                batt_reg    <= cfg_reg[`PSS_CFG_USBSUS];
                trickle_reg <= !cfg_reg[`PSS_CFG_USBSUS];
            end else if (state_reg == st_off && startup) begin
                batt_reg    <= 1'b0;
                trickle_reg <= 1'b0;
            end
        end
    end

    // outputs straight from flops
    assign o_avs_readdata              = rdata_reg;
    assign o_avs_waitrequest           = wait_reg;
    assign o_supply_en                 = en_reg;
    assign o_startup_voltage_threshold = cfg_reg[`PSS_CFG_THR_LSB +: 3];
    assign o_fast_charge_allow         = fast_reg;
    assign o_usb_trickle_100ma         = trickle_reg;
    assign o_start_on_battery          = batt_reg;
    assign o_wake_summary_irq          = irq_reg;
endmodule : pss_seq_top
`default_nettype wire

// ==== pkg/pss_map.svh ====
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// register indices (byte address is four times the index)
`define PSS_IDX_HIB      8'h05
`define PSS_IDX_STAT     8'h1f
`define PSS_IDX_MASK     8'h27
`define PSS_IDX_CFG      8'h40
`define PSS_IDX_INFO     8'h41
`define PSS_IDX_SLOT0    8'h48

// field positions
`define PSS_HIB_BIT      15
`define PSS_CFG_ALARM    0
`define PSS_CFG_ONPOL    1
`define PSS_CFG_USBSUS   2
`define PSS_CFG_WAKEPOL  3
`define PSS_CFG_PWRPOL   4
`define PSS_CFG_THR_LSB  8
`define PSS_CFG_RESTART  13
`define PSS_F_WAKE       0
`define PSS_F_KEY        1
`define PSS_F_PWR        2
`define PSS_F_WDOG       3
`define PSS_F_CONV       4
`define PSS_F_HIB        5
`define PSS_F_OFF        6

// reset values and masks
`define PSS_CFG_RST      16'h0002
`define PSS_STAT_MASK    16'h007f
`define PSS_SLOT_RST     4'h0

// sizes
`define PSS_NSUP         10
`define PSS_LAST_SLOT    4'hd
`define PSS_RETRY_MAX    4'h8

// timing: times in microseconds, clock in MHz
`define PSS_CLK_MHZ      40
`define PSS_QUAL_US      40000
`define PSS_SLOT_US      1280
`define PSS_RETRY_US     200000
`define PSS_QUAL_CYC     (`PSS_QUAL_US * `PSS_CLK_MHZ)
`define PSS_SLOT_CYC     (`PSS_SLOT_US * `PSS_CLK_MHZ)
`define PSS_RETRY_CYC    (`PSS_RETRY_US * `PSS_CLK_MHZ)

`endif

// ==== pkg/pss_pkg.sv ====
package pss_pkg;
    typedef enum logic [2:0] {
        st_off,
        st_seq,
        st_active,
        st_hib,
        st_retry
    } pss_state_t;

    typedef logic [23:0] pss_count_t;
endpackage : pss_pkg

// ==== pkg/pss_qual_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// one qualified input: level in, one-cycle hit out
interface pss_qual_if;
    logic ce;
    logic level;
    logic hit;
    modport owner (output ce, output level, input hit);
    modport timer (input ce, input level, output hit);
endinterface : pss_qual_if
`default_nettype wire

// ==== design/pss_qual.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.svh"
// hold-time qualifier: pulses hit once the level has stood for CYCLES clocks
module pss_qual #(
    parameter int unsigned CYCLES = `PSS_QUAL_CYC
) (
    input  wire logic      i_clk_sys,
    input  wire logic      i_rst_n,
    pss_qual_if.timer      q
);
    import pss_pkg::*;

    pss_count_t cnt_reg;
    logic       hit_reg;
    wire        at_end  = (cnt_reg == pss_count_t'(CYCLES - 1));
    wire        held    = (cnt_reg == pss_count_t'(CYCLES));

    assign q.hit = hit_reg;

    // counter restarts whenever the level drops early
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
            hit_reg <= 1'b0;
        end else if (q.ce) begin
            if (!q.level)
                cnt_reg <= '0;
            else if (!held)
                cnt_reg <= cnt_reg + 24'h000001;
            hit_reg <= q.level && at_end;
        end
    end
endmodule : pss_qual
`default_nettype wire

// ==== tb/pss_seq_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.svh"
// state, bus and sequencing relations seen at the top ports
module pss_seq_sva #(
    parameter int unsigned SLOT_CYC = `PSS_SLOT_CYC
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    input  wire logic [9:0]           i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [31:0]          i_avs_writedata,
    input  wire logic [3:0]           i_avs_byteenable,
    input  wire logic [31:0]          o_avs_readdata,
    input  wire logic                 o_avs_waitrequest,
    input  wire logic                 i_hib_level_req,
    input  wire logic                 i_line_above_thr,
    input  wire logic                 i_supply_fault,
    input  wire logic [`PSS_NSUP-1:0] o_supply_en,
    input  wire logic                 o_fast_charge_allow,
    input  wire logic                 o_wake_summary_irq
);
    logic [`PSS_NSUP-1:0] en_reg;
    logic [23:0]          gap_reg;
    logic                 done_w;
    logic                 rise_w;
    // bus answer edge; a new enable while older ones are up
    assign done_w = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
    assign rise_w = (|(o_supply_en & ~en_reg)) & (|en_reg);
    // cycles since the enables last changed, saturating
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_reg  <= '0;
            gap_reg <= '0;
        end else begin
            en_reg  <= o_supply_en;
            gap_reg <= (o_supply_en != en_reg) ? 24'h0 : gap_reg + {23'h0, ~&gap_reg};
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    AST_WAIT_ONE: assert property (
        (i_avs_read | i_avs_write) & o_avs_waitrequest & i_ce |=> !o_avs_waitrequest)
        else $error("bus answer late");
    AST_RD_UPPER: assert property (
        !o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000)
        else $error("upper read half set");
    AST_HIB_SW: assert property (
        done_w && i_avs_write && i_avs_address[9:2] == `PSS_IDX_HIB && i_avs_byteenable[1]
        && i_avs_writedata[`PSS_HIB_BIT] && o_fast_charge_allow |-> ##[1:4] !o_fast_charge_allow)
        else $error("no hibernate after bit set");
    AST_HIB_LVL: assert property (
        i_hib_level_req && o_fast_charge_allow |-> ##[1:4] !o_fast_charge_allow)
        else $error("no hibernate on level request");
    AST_FAULT_OFF: assert property (
        i_supply_fault && (|o_supply_en) |-> ##[1:4] o_supply_en == '0)
        else $error("supplies kept after fault");
    AST_SLOT_GAP: assert property (
        rise_w |-> gap_reg >= SLOT_CYC - 1)
        else $error("slot advanced early");
    AST_IRQ_FALL: assert property (
        $fell(o_wake_summary_irq) |-> $past(done_w) || $past(done_w, 2) || $past(done_w, 3))
        else $error("irq dropped without access");
    AST_LINE_GATE: assert property (
        (|o_supply_en) && !(|en_reg) |-> $past(i_line_above_thr, 2)
        || $past(i_line_above_thr, 3) || $past(i_line_above_thr, 4))
        else $error("start without line supply");
endmodule : pss_seq_sva
bind pss_seq_top pss_seq_sva #(.SLOT_CYC(SLOT_CYC)) u_sva (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_hib_level_req(i_hib_level_req),
    .i_line_above_thr(i_line_above_thr), .i_supply_fault(i_supply_fault),
    .o_supply_en(o_supply_en), .o_fast_charge_allow(o_fast_charge_allow),
    .o_wake_summary_irq(o_wake_summary_irq));
`default_nettype wire

// ==== tb/pss_supply_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.svh"
// supply blocks: good one cycle after enable, held low while stalled
module pss_supply_model (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire logic [`PSS_NSUP-1:0] i_supply_en,
    input  wire logic                 i_stall,
    output logic [`PSS_NSUP-1:0]      o_supply_good
);
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_supply_good <= '0;
        end else begin
            o_supply_good <= i_stall ? '0 : i_supply_en;
        end
    end
endmodule : pss_supply_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.svh"
// register-level test of the state and start-up sequencer
module tb;
    localparam int QC = 20;
    logic clk, rst_n, rd, wr, key, wk, pw, al, ad, usb, line, he, hl, wdg, flt, stl;
    logic [9:0]  addr;
    logic [31:0] wd, q;
    logic [9:0]  en, good;
    logic [2:0]  thr;
    logic        wt, fast, trk, bat, irq;
    int          num_errors = 0;
    int          checked = 0;
    wire  [31:0] enw = {22'h0, en};
    wire  [2:0]  mon = {irq, |en, fast};
    pss_seq_top #(.QUAL_CYC(QC), .SLOT_CYC(8), .RETRY_CYC(16)) i_dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h3), .o_avs_readdata(q),
        .o_avs_waitrequest(wt), .i_on_key(key), .i_gpio_wake(wk), .i_power_on_request_input(pw),
        .i_rtc_alarm(al), .i_adaptor_sense_input(ad), .i_usb_above_4v(usb),
        .i_line_above_thr(line), .i_hib_edge_req(he), .i_hib_level_req(hl),
        .i_watchdog_reset(wdg), .i_supply_good(good), .i_supply_fault(flt), .o_supply_en(en),
        .o_startup_voltage_threshold(thr), .o_fast_charge_allow(fast),
        .o_usb_trickle_100ma(trk), .o_start_on_battery(bat), .o_wake_summary_irq(irq));
    pss_supply_model i_sup (.i_clk_sys(clk), .i_rst_n(rst_n), .i_supply_en(en),
        .i_stall(stl), .o_supply_good(good));
    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic oops;
        num_errors++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        test_done();
    endtask : oops
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] x, input logic [15:0] d,
                       output logic [31:0] v);
        int n = 0;
        addr <= {x, 2'b00};
        wd <= {16'h0000, d};
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 40);
        v = q;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 40) oops();
        @(posedge clk);
    endtask : bus
    task automatic w(input logic [7:0] x, input logic [15:0] d);
        logic [31:0] v;
        bus(1'b1, x, d, v);
    endtask : w
    task automatic r(input logic [7:0] x, input logic [15:0] e);
        logic [31:0] v;
        bus(1'b0, x, 16'h0000, v);
        chk(v, {16'h0000, e});
    endtask : r
    // bounded wait on fast charge, any enable or irq
    task automatic till(input int b, input logic v);
        int n = 0;
        while (mon[b] !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) oops();
    endtask : till
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        logic [31:0] v;
        {rst_n, rd, wr, wk, pw, al, ad, usb, he, hl, wdg, flt, stl, addr, wd} = '0;
        {key, line} = 2'b11;
        cyc(6);
        rst_n <= 1'b1;
        cyc(1);
        r(`PSS_IDX_HIB, 16'h0000);
        r(`PSS_IDX_MASK, 16'h0000);
        r(`PSS_IDX_CFG, 16'h0002);
        r(8'h30, 16'h0000);
        w(`PSS_IDX_SLOT0 + 8'h01, 16'h0002);
        w(`PSS_IDX_SLOT0 + 8'h02, 16'h000d);
        key <= 1'b0;
        cyc(QC - 4);
        key <= 1'b1;
        cyc(2);
        chk(enw, 32'h0);
        key <= 1'b0;
        stl <= 1'b1;
        till(1, 1'b1);
        chk(enw, 32'h3f9);
        cyc(60);
        chk(fast, 1'b0);
        key <= 1'b1;
        stl <= 1'b0;
        till(0, 1'b1);
        chk(enw, 32'h3ff);
        chk(irq, 1'b1);
        r(`PSS_IDX_STAT, 16'h0042);
        r(`PSS_IDX_STAT, 16'h0000);
        w(`PSS_IDX_MASK, 16'h007f);
        wdg <= 1'b1;
        cyc(4);
        wdg <= 1'b0;
        chk(irq, 1'b0);
        r(`PSS_IDX_STAT, 16'h0008);
        w(`PSS_IDX_MASK, 16'h0000);
        w(`PSS_IDX_HIB, 16'h8000);
        till(0, 1'b0);
        r(`PSS_IDX_HIB, 16'h8000);
        w(`PSS_IDX_HIB, 16'h0000);
        till(0, 1'b1);
        hl <= 1'b1;
        till(0, 1'b0);
        hl <= 1'b0;
        till(0, 1'b1);
        he <= 1'b1;
        till(0, 1'b0);
        he <= 1'b0;
        wk <= 1'b1;
        till(0, 1'b1);
        wk <= 1'b0;
        r(`PSS_IDX_STAT, 16'h0021);
        he <= 1'b1;
        till(0, 1'b0);
        he <= 1'b0;
        al <= 1'b1;
        cyc(10);
        chk(fast, 1'b0);
        al <= 1'b0;
        w(`PSS_IDX_CFG, 16'h0003);
        al <= 1'b1;
        till(0, 1'b1);
        al <= 1'b0;
        he <= 1'b1;
        till(0, 1'b0);
        he <= 1'b0;
        cyc(2);
        he <= 1'b1;
        till(0, 1'b1);
        he <= 1'b0;
        r(`PSS_IDX_STAT, 16'h0020);
        pw <= 1'b1;
        cyc(QC + 4);
        pw <= 1'b0;
        chk(fast, 1'b1);
        r(`PSS_IDX_STAT, 16'h0004);
        he <= 1'b1;
        till(0, 1'b0);
        he <= 1'b0;
        flt <= 1'b1;
        till(1, 1'b0);
        flt <= 1'b0;
        line <= 1'b0;
        usb <= 1'b1;
        cyc(20);
        chk(enw, 32'h0);
        {usb, line} <= 2'b01;
        cyc(2);
        usb <= 1'b1;
        till(0, 1'b1);
        chk({trk, bat}, 2'b10);
        r(`PSS_IDX_STAT, 16'h0040);
        w(`PSS_IDX_CFG, 16'h2106);
        chk(thr, 3'h1);
        flt <= 1'b1;
        cyc(400);
        flt <= 1'b0;
        chk(enw, 32'h0);
        r(`PSS_IDX_STAT, 16'h0010);
        bus(1'b0, `PSS_IDX_INFO, 16'h0000, v);
        chk(v & 32'h7f0, 32'h0);
        w(`PSS_IDX_CFG, 16'h0106);
        usb <= 1'b0;
        cyc(2);
        usb <= 1'b1;
        till(0, 1'b1);
        chk({trk, bat}, 2'b01);
        flt <= 1'b1;
        till(1, 1'b0);
        flt <= 1'b0;
        cyc(30);
        chk(enw, 32'h0);
        ad <= 1'b1;
        till(0, 1'b1);
        test_done();
    end
endmodule : tb
`default_nettype wire
